/* File: hub_port_cfg_pkg.sv */
// constants for the hub per-port configuration register bank
package hub_port_cfg_pkg;
	localparam int PORT_COUNT = 4;
	localparam logic [7:0] CHARGE_SUPPORT_ENABLE_OFFSET = 8'h06;
	localparam logic [7:0] PORT_REMOVABLE_CONFIG_OFFSET = 8'h07;
	localparam logic [7:0] PORT_IN_USE_CONFIG_OFFSET = 8'h08;
	localparam int FIELD_LSB = 0;
	localparam int FIELD_MSB = 3;
	localparam logic [3:0] RESERVED_READ_VALUE = 4'h0;
	localparam logic [3:0] FIELD_RESET_VALUE = 4'h0;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
	// edges after reset release before the third strap stage holds a sampled value
	localparam logic [1:0] STRAP_FILL_CYCLES = 2'h3;
	localparam logic [1:0] FILL_COUNT_RESET = 2'h0;

	typedef enum logic [1:0] {
		ST_FILL = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN = 2'b11
	} strap_state_t;
endpackage

/* File: hub_port_config_regs.sv */
// per-port charging, removable and port-in-use configuration registers
`timescale 1ns/1ps
`default_nettype none

module hub_port_config_regs
	import hub_port_cfg_pkg::*;
#(
	parameter int PORTS = PORT_COUNT
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// strap pins, asynchronous to core_clk
	input wire logic [PORTS-1:0] power_on_charge_strap,
	input wire logic [PORTS-1:0] amber_led_removable_strap,
	input wire logic [PORTS-1:0] green_led_port_enable_strap,
	// configuration access from the eeprom loader or smbus slave
	input wire logic cfg_mode_en,
	input wire logic [7:0] cfg_addr,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_rd,
	output logic [7:0] cfg_rdata,
	// configuration towards the port logic
	output logic [PORTS-1:0] charge_port_enable,
	output logic [PORTS-1:0] port_removable,
	output logic [PORTS-1:0] port_in_use,
	output logic straps_loaded
);

	// stage one is read only by stage two; stages two and three decide settling
	logic [PORTS-1:0] chg_s1;
	logic [PORTS-1:0] chg_s2;
	logic [PORTS-1:0] chg_s3;
	logic [PORTS-1:0] rmb_s1;
	logic [PORTS-1:0] rmb_s2;
	logic [PORTS-1:0] rmb_s3;
	logic [PORTS-1:0] use_s1;
	logic [PORTS-1:0] use_s2;
	logic [PORTS-1:0] use_s3;
	strap_state_t state;
	logic [1:0] fill_count;
	logic fill_done;
	logic chg_stable;
	logic rmb_stable;
	logic use_stable;
	logic straps_stable;
	logic capture;
	logic wr_ok;
	logic wr_charge;
	logic wr_removable;
	logic wr_in_use;
	logic [PORTS-1:0] next_charge_enable;
	logic [7:0] next_rdata;

	// power-on charge straps
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			chg_s1 <= '0;
			chg_s2 <= '0;
			chg_s3 <= '0;
		end else begin
			chg_s1 <= power_on_charge_strap;
			chg_s2 <= chg_s1;
			chg_s3 <= chg_s2;
		end
	end

	// amber-led removable straps
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rmb_s1 <= '0;
			rmb_s2 <= '0;
			rmb_s3 <= '0;
		end else begin
			rmb_s1 <= amber_led_removable_strap;
			rmb_s2 <= rmb_s1;
			rmb_s3 <= rmb_s2;
		end
	end

	// green-led port-enable straps
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			use_s1 <= '0;
			use_s2 <= '0;
			use_s3 <= '0;
		end else begin
			use_s1 <= green_led_port_enable_strap;
			use_s2 <= use_s1;
			use_s3 <= use_s2;
		end
	end

	// a group counts as settled once its second and third stages agree
	assign chg_stable = (chg_s2 == chg_s3);
	assign rmb_stable = (rmb_s2 == rmb_s3);
	assign use_stable = (use_s2 == use_s3);
	assign straps_stable = chg_stable && rmb_stable && use_stable;
	assign fill_done = (fill_count == STRAP_FILL_CYCLES - 2'h1);
	assign capture = (state == ST_SETTLE) && straps_stable;
	// writes before capture would be lost to the strap load, so they are refused
	assign wr_ok = cfg_wr && cfg_mode_en && (state == ST_RUN);
	assign wr_charge = wr_ok && (cfg_addr == CHARGE_SUPPORT_ENABLE_OFFSET);
	assign wr_removable = wr_ok && (cfg_addr == PORT_REMOVABLE_CONFIG_OFFSET);
	assign wr_in_use = wr_ok && (cfg_addr == PORT_IN_USE_CONFIG_OFFSET);

	// the mask uses the in-use field as it stands before this edge
	always_comb begin
		next_charge_enable = (charge_port_enable & ~port_in_use)
			| (cfg_wdata[PORTS-1:0] & port_in_use);
	end

	// counts the edges that fill the synchroniser stages after reset release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fill_count <= FILL_COUNT_RESET;
		end else if (state == ST_FILL) begin
			fill_count <= fill_count + 2'h1;
		end
	end

	// one-shot strap capture after reset release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= ST_FILL;
		end else begin
			unique case (state)
				ST_FILL: begin
					if (fill_done) begin
						state <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (straps_stable) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					state <= ST_RUN;
				end
				default: begin
					state <= ST_FILL;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			straps_loaded <= 1'b0;
		end else if (capture) begin
			straps_loaded <= 1'b1;
		end
	end

	// charge support: strap default, then writes limited to ports in use
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			charge_port_enable <= FIELD_RESET_VALUE[PORTS-1:0];
		end else if (capture) begin
			charge_port_enable <= chg_s3;
		end else if (wr_charge) begin
			charge_port_enable <= next_charge_enable;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_removable <= FIELD_RESET_VALUE[PORTS-1:0];
		end else if (capture) begin
			port_removable <= rmb_s3;
		end else if (wr_removable) begin
			port_removable <= cfg_wdata[PORTS-1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_in_use <= FIELD_RESET_VALUE[PORTS-1:0];
		end else if (capture) begin
			port_in_use <= use_s3;
		end else if (wr_in_use) begin
			port_in_use <= cfg_wdata[PORTS-1:0];
		end
	end

	// read data: field in the low nibble, upper bits forced to zero
	always_comb begin
		next_rdata = UNMAPPED_READ_VALUE;
		unique case (cfg_addr)
			CHARGE_SUPPORT_ENABLE_OFFSET: begin
				next_rdata = {RESERVED_READ_VALUE, charge_port_enable};
			end
			PORT_REMOVABLE_CONFIG_OFFSET: begin
				next_rdata = {RESERVED_READ_VALUE, port_removable};
			end
			PORT_IN_USE_CONFIG_OFFSET: begin
				next_rdata = {RESERVED_READ_VALUE, port_in_use};
			end
			default: begin
				next_rdata = UNMAPPED_READ_VALUE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_rdata <= UNMAPPED_READ_VALUE;
		end else if (cfg_rd) begin
			cfg_rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

/* File: hub_port_cfg_asserts.sv */
// checker for the port configuration registers
`timescale 1ns/1ps
`default_nettype none
module hub_port_cfg_asserts #(parameter int PORTS = 4) (
	input wire logic core_clk, rst, cfg_mode_en, cfg_wr, cfg_rd, straps_loaded,
	input wire logic [7:0] cfg_addr, cfg_wdata, cfg_rdata,
	input wire logic [PORTS-1:0] power_on_charge_strap, amber_led_removable_strap,
	input wire logic [PORTS-1:0] green_led_port_enable_strap, charge_port_enable,
	input wire logic [PORTS-1:0] port_removable, port_in_use
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence wr_at(a);
		cfg_wr && cfg_mode_en && straps_loaded && cfg_addr == a;
	endsequence
	a_rsvd_zero:
		assert property (cfg_rd |=> !cfg_rdata[7:4]) else $error("rsvd");
	a_load_time:
		assert property ($fell(rst) |-> ##[1:5] straps_loaded) else $error("late");
	a_strap_cap:
		assert property ($rose(straps_loaded) |-> charge_port_enable == power_on_charge_strap
			&& port_removable == amber_led_removable_strap
			&& port_in_use == green_led_port_enable_strap) else $error("cap");
	a_cfg_hold:
		assert property (straps_loaded && !(cfg_wr && cfg_mode_en) |=> $stable(port_in_use)
			&& $stable(charge_port_enable) && $stable(port_removable)) else $error("hold");
	a_rmbl_wr:
		assert property (wr_at(8'h07) |=> port_removable == $past(cfg_wdata[PORTS-1:0])) else $error("rm");
	a_used_wr:
		assert property (wr_at(8'h08) |=> port_in_use == $past(cfg_wdata[PORTS-1:0])) else $error("use");
	a_charge_mask:
		assert property (wr_at(8'h06) |=> charge_port_enable == ($past(cfg_wdata[PORTS-1:0])
			& $past(port_in_use) | $past(charge_port_enable) & ~$past(port_in_use))) else $error("chg");
	a_read_used:
		assert property (cfg_rd && cfg_addr == 8'h08 |=> cfg_rdata[PORTS-1:0] == $past(port_in_use))
			else $error("rd");
endmodule
bind hub_port_config_regs hub_port_cfg_asserts #(.PORTS(PORTS)) u_chk (.*);
`default_nettype wire

/* File: cfg_host_model.sv */
// stand-in for the eeprom loader or smbus host on the register port
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
	input wire logic core_clk,
	output logic cfg_wr, cfg_rd,
	output logic [7:0] cfg_addr, cfg_wdata
);
	initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h0;
	// released address and data are inverted so a stale value is never taken as live
	task automatic acc(logic w, logic [7:0] a, d);
		@(posedge core_clk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, d};
		@(posedge core_clk);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {2'b00, ~a, ~d};
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// bench for the port configuration registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk = 0, rst = 1, cfg_mode_en = 1, cfg_wr, cfg_rd, straps_loaded;
	logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
	logic [3:0] power_on_charge_strap = 4'hb, amber_led_removable_strap = 4'he;
	logic [3:0] green_led_port_enable_strap = 4'h5, charge_port_enable, port_removable, port_in_use;
	int n_fail = 0, n_checks = 0, cyc = 0;
	initial forever #5 core_clk = ~core_clk;
	hub_port_config_regs u_dut (.*);
	cfg_host_model u_host (.*);
	task automatic chk(logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rd(logic [7:0] a, exp);
		u_host.acc(1'b0, a, 8'h00);
		#1 chk(cfg_rdata, exp);
	endtask
	task automatic boot(logic [7:0] e0, e1);
		repeat (2) @(posedge core_clk);
		rst <= 0;
		repeat (5) @(posedge core_clk);
		#1 chk({charge_port_enable, port_removable}, e0);
		chk({3'h0, straps_loaded, port_in_use}, e1);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 300) begin
			n_fail++;
			tally_and_finish;
		end
	end
	initial begin
		boot(8'hbe, 8'h15);
		@(posedge core_clk) {power_on_charge_strap, amber_led_removable_strap,
			green_led_port_enable_strap} <= 12'hfff;
		rd(8'h06, 8'h0b);
		rd(8'h07, 8'h0e);
		rd(8'h08, 8'h05);
		rd(8'h09, 8'h00);
		$display("strap test done");
		u_host.acc(1'b1, 8'h06, 8'hf4);
		rd(8'h06, 8'h0e);
		u_host.acc(1'b1, 8'h08, 8'hf3);
		u_host.acc(1'b1, 8'h06, 8'h07);
		rd(8'h06, 8'h0f);
		rd(8'h08, 8'h03);
		u_host.acc(1'b1, 8'h07, 8'hfc);
		rd(8'h07, 8'h0c);
		@(posedge core_clk) cfg_mode_en <= 0;
		u_host.acc(1'b1, 8'h07, 8'h01);
		rd(8'h07, 8'h0c);
		$display("write test done");
		@(posedge core_clk) rst <= 1;
		boot(8'hff, 8'h1f);
		$display("reset test done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
